// ### rtl/tc8_pkg.sv
`default_nettype none
package tc8_pkg;
   // ======================================================
   // Register addresses.
   localparam logic [2:0] ADR_CTRL_A = 3'h0;
   localparam logic [2:0] ADR_CTRL_B = 3'h1;
   localparam logic [2:0] ADR_COUNT  = 3'h2;
   localparam logic [2:0] ADR_CMP_A  = 3'h3;
   localparam logic [2:0] ADR_CMP_B  = 3'h4;
   localparam logic [2:0] ADR_MASK   = 3'h5;
   localparam logic [2:0] ADR_FLAGS  = 3'h6;
   // ======================================================
   // Field positions.
   localparam int CA_OMA = 6;
   localparam int CA_OMB = 4;
   localparam int CA_WM  = 0;
   localparam int CB_FA  = 7;
   localparam int CB_FB  = 6;
   localparam int CB_WM2 = 3;
   localparam int CB_CS  = 0;
   localparam int FL_OVF = 0;
   localparam int FL_MA  = 1;
   localparam int FL_MB  = 2;
   // ======================================================
   // Values.
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   localparam logic [7:0] CNT_ONE    = 8'h01;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [2:0] RST_FLAGS  = 3'h0;
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_CORE    = 3'h1;
   localparam logic [2:0] CS_EXT_F   = 3'h6;
   localparam logic [2:0] CS_EXT_R   = 3'h7;
   localparam logic [2:0] WM_NORMAL  = 3'h0;
   localparam logic [2:0] WM_PC_MAX  = 3'h1;
   localparam logic [2:0] WM_CTC     = 3'h2;
   localparam logic [2:0] WM_FST_MAX = 3'h3;
   localparam logic [2:0] WM_PC_TOP  = 3'h5;
   localparam logic [2:0] WM_FST_TOP = 3'h7;
   localparam logic [1:0] OM_OFF     = 2'h0;
   localparam logic [1:0] OM_TOGGLE  = 2'h1;
   localparam logic [1:0] OM_CLEAR   = 2'h2;
   localparam logic [1:0] OM_SET     = 2'h3;
   typedef enum logic {TC8_UP, TC8_DOWN} tc8_dir_t;
endpackage
`default_nettype wire

// ### rtl/tc8_timer.sv
`default_nettype none
// ======================================================
// Compare channel.
module tc8_chan
   import tc8_pkg::*;
#(
   parameter bit IS_A = 1'b0
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       tick_i,
   input  wire logic [7:0] cnt_i,
   input  wire logic       block_i,
   input  wire logic [2:0] wm_i,
   input  wire tc8_dir_t   dir_i,
   input  wire logic       wrap_i,
   input  wire logic       load_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [1:0] om_i,
   input  wire logic       force_i,
   output logic      [7:0] cmp_rd_o,
   output logic      [7:0] cmp_o,
   output logic            hit_o,
   output logic            oc_o
);
   logic [7:0] buf_q;
   logic       oc_d, pwm, tgl_ok;
   assign pwm      = wm_i[0];
   assign tgl_ok   = IS_A && wm_i[2];
   assign cmp_rd_o = pwm ? buf_q : cmp_o;
   assign hit_o    = tick_i && (cnt_i == cmp_o) && !block_i;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buf_q <= RST_BYTE;
         cmp_o <= RST_BYTE;
      end else if (ce_i) begin
         if (wr_i) begin
            buf_q <= wdata_i;
         end
         if (wr_i && !pwm) begin
            cmp_o <= wdata_i;
         end else if (pwm && load_i) begin
            cmp_o <= buf_q;
         end
      end
   end
   always_comb begin
      oc_d = oc_o;
      if (!pwm) begin
         if (hit_o || force_i) begin
            case (om_i)
               OM_TOGGLE: oc_d = !oc_o;
               OM_CLEAR:  oc_d = 1'b0;
               OM_SET:    oc_d = 1'b1;
               default:   oc_d = oc_o;
            endcase
         end
      end else if (wm_i[1]) begin
         if (wrap_i && om_i == OM_CLEAR) begin
            oc_d = 1'b1;
         end else if (wrap_i && om_i == OM_SET) begin
            oc_d = 1'b0;
         end else if (hit_o) begin
            case (om_i)
               OM_TOGGLE: oc_d = tgl_ok ? !oc_o : oc_o;
               OM_CLEAR:  oc_d = 1'b0;
               OM_SET:    oc_d = 1'b1;
               default:   oc_d = oc_o;
            endcase
         end
      end else if (hit_o) begin
         case (om_i)
            OM_TOGGLE: oc_d = tgl_ok ? !oc_o : oc_o;
            OM_CLEAR:  oc_d = (dir_i == TC8_DOWN);
            OM_SET:    oc_d = (dir_i == TC8_UP);
            default:   oc_d = oc_o;
         endcase
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oc_o <= 1'b0;
      end else if (ce_i) begin
         oc_o <= oc_d;
      end
   end
endmodule

// ======================================================
// Timer top.
module tc8_timer
   import tc8_pkg::*;
(
   // Clock, reset, enable.
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       ce_i,
   // Register port.
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // Tick sources.
   input  wire logic       presc_tick_i,
   input  wire logic       ext_clk_i,
   // Interrupts.
   input  wire logic [2:0] irq_ack_i,
   output logic      [2:0] irq_o,
   // Port pins, bit 0 is channel A.
   input  wire logic [1:0] port_data_i,
   input  wire logic [1:0] port_dir_i,
   output logic      [1:0] pin_o,
   output logic      [1:0] pin_oe_n_o
);
   logic [1:0] rst_sync_q;
   logic [2:0] ext_q;
   logic [7:0] ctrl_a_q;
   logic [4:0] ctrl_b_q;
   logic [7:0] cnt_q, cnt_d;
   tc8_dir_t   dir_q, dir_d;
   logic [2:0] mask_q;
   logic [2:0] flags_q, flags_set, flags_clr;
   logic [2:0] wm, cs;
   logic [7:0] top_v, cmp_a, rd_a, rd_b, rd_d;
   logic       rst_n, block_q, at_top, at_bot;
   logic       tk, tk_run, cnt_wr, wr_b;
   logic       ovf_set, load, wrap;
   logic       hit_a, hit_b, oc_a, oc_b;
   // ======================================================
   // Reset release and pin synchroniser.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ext_q <= 3'h0;
      end else if (ce_i) begin
         ext_q <= {ext_q[1:0], ext_clk_i};
      end
   end
   // ======================================================
   // Mode decode and tick select.
   assign wm     = {ctrl_b_q[CB_WM2], ctrl_a_q[CA_WM +: 2]};
   assign cs     = ctrl_b_q[CB_CS +: 3];
   assign top_v  = (wm[2] || wm == WM_CTC) ? cmp_a : CNT_MAX;
   assign at_top = (cnt_q == top_v);
   assign at_bot = (cnt_q == CNT_BOTTOM);
   assign cnt_wr = ce_i && wr_i && addr_i == ADR_COUNT;
   assign wr_b   = ce_i && wr_i && addr_i == ADR_CTRL_B;
   always_comb begin
      case (cs)
         CS_STOP:  tk = 1'b0;
         CS_CORE:  tk = ce_i;
         CS_EXT_F: tk = ce_i && ext_q[2] && !ext_q[1];
         CS_EXT_R: tk = ce_i && ext_q[1] && !ext_q[2];
         default:  tk = ce_i && presc_tick_i;
      endcase
   end
   assign tk_run = tk && !cnt_wr;
   // ======================================================
   // Counting sequence.
   always_comb begin
      cnt_d   = cnt_q + CNT_ONE;
      dir_d   = dir_q;
      ovf_set = 1'b0;
      load    = 1'b0;
      wrap    = 1'b0;
      case (wm)
         WM_CTC: begin
            ovf_set = (cnt_q == CNT_MAX);
            if (at_top) begin
               cnt_d = CNT_BOTTOM;
            end
         end
         WM_FST_MAX, WM_FST_TOP: begin
            if (at_top) begin
               cnt_d   = CNT_BOTTOM;
               ovf_set = 1'b1;
               load    = 1'b1;
               wrap    = 1'b1;
            end
         end
         WM_PC_MAX, WM_PC_TOP: begin
            if (dir_q == TC8_UP) begin
               if (at_top) begin
                  dir_d = TC8_DOWN;
                  cnt_d = cnt_q - CNT_ONE;
                  load  = 1'b1;
               end
            end else if (at_bot) begin
               dir_d   = TC8_UP;
               ovf_set = 1'b1;
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         default: begin
            ovf_set = (cnt_q == CNT_MAX);
         end
      endcase
   end
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= RST_BYTE;
      end else if (cnt_wr) begin
         cnt_q <= wdata_i;
      end else if (tk) begin
         cnt_q <= cnt_d;
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= TC8_UP;
      end else if (tk_run) begin
         dir_q <= wm[0] ? dir_d : TC8_UP;
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         block_q <= 1'b0;
      end else if (cnt_wr) begin
         block_q <= 1'b1;
      end else if (tk) begin
         block_q <= 1'b0;
      end
   end
   // ======================================================
   // Control and mask registers.
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_a_q <= RST_BYTE;
         ctrl_b_q <= RST_BYTE[4:0];
         mask_q   <= RST_FLAGS;
      end else if (ce_i && wr_i) begin
         if (addr_i == ADR_CTRL_A) begin
            ctrl_a_q <= wdata_i;
         end
         if (addr_i == ADR_CTRL_B) begin
            ctrl_b_q <= wdata_i[4:0];
         end
         if (addr_i == ADR_MASK) begin
            mask_q <= wdata_i[2:0];
         end
      end
   end
   // ======================================================
   // Compare channels.
   tc8_chan #(.IS_A(1'b1)) u_chan_a (
      .clk_i    (core_clk_i),
      .rst_n_i  (rst_n),
      .ce_i     (ce_i),
      .tick_i   (tk),
      .cnt_i    (cnt_q),
      .block_i  (block_q),
      .wm_i     (wm),
      .dir_i    (dir_q),
      .wrap_i   (wrap && tk_run),
      .load_i   (load && tk_run),
      .wr_i     (ce_i && wr_i && addr_i == ADR_CMP_A),
      .wdata_i  (wdata_i),
      .om_i     (ctrl_a_q[CA_OMA +: 2]),
      .force_i  (wr_b && wdata_i[CB_FA] && !wm[0]),
      .cmp_rd_o (rd_a),
      .cmp_o    (cmp_a),
      .hit_o    (hit_a),
      .oc_o     (oc_a)
   );
   tc8_chan #(.IS_A(1'b0)) u_chan_b (
      .clk_i    (core_clk_i),
      .rst_n_i  (rst_n),
      .ce_i     (ce_i),
      .tick_i   (tk),
      .cnt_i    (cnt_q),
      .block_i  (block_q),
      .wm_i     (wm),
      .dir_i    (dir_q),
      .wrap_i   (wrap && tk_run),
      .load_i   (load && tk_run),
      .wr_i     (ce_i && wr_i && addr_i == ADR_CMP_B),
      .wdata_i  (wdata_i),
      .om_i     (ctrl_a_q[CA_OMB +: 2]),
      .force_i  (wr_b && wdata_i[CB_FB] && !wm[0]),
      .cmp_rd_o (rd_b),
      .cmp_o    (),
      .hit_o    (hit_b),
      .oc_o     (oc_b)
   );
   // ======================================================
   // Flags and interrupt requests.
   assign flags_set = {hit_b, hit_a, tk_run && ovf_set};
   assign flags_clr = irq_ack_i
                    | ((wr_i && addr_i == ADR_FLAGS) ? wdata_i[2:0] : RST_FLAGS);
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= RST_FLAGS;
         irq_o   <= RST_FLAGS;
      end else if (ce_i) begin
         flags_q <= flags_set | (flags_q & ~flags_clr);
         irq_o   <= flags_q & mask_q;
      end
   end
   // ======================================================
   // Read data and pins.
   always_comb begin
      case (addr_i)
         ADR_CTRL_A: rd_d = ctrl_a_q;
         ADR_CTRL_B: rd_d = {3'h0, ctrl_b_q};
         ADR_COUNT:  rd_d = cnt_q;
         ADR_CMP_A:  rd_d = rd_a;
         ADR_CMP_B:  rd_d = rd_b;
         ADR_MASK:   rd_d = {5'h00, mask_q};
         ADR_FLAGS:  rd_d = {5'h00, flags_q};
         default:    rd_d = RST_BYTE;
      endcase
   end
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o    <= RST_BYTE;
         pin_o      <= 2'h0;
         pin_oe_n_o <= 2'h3;
      end else if (ce_i) begin
         rdata_o       <= rd_i ? rd_d : RST_BYTE;
         pin_o[0]      <= (ctrl_a_q[CA_OMA +: 2] != OM_OFF) ? oc_a : port_data_i[0];
         pin_o[1]      <= (ctrl_a_q[CA_OMB +: 2] != OM_OFF) ? oc_b : port_data_i[1];
         pin_oe_n_o    <= ~port_dir_i;
      end
   end
   // ======================================================
   // Checks.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n);
   chk_stop_hold:  assert property ((cs == CS_STOP && !cnt_wr) |=> $stable(cnt_q))
      else $error("counter moved while stopped");
   chk_cnt_write:  assert property (cnt_wr |=> cnt_q == $past(wdata_i))
      else $error("counter write lost");
   chk_norm_inc:   assert property ((tk_run && wm == WM_NORMAL)
                      |=> cnt_q == $past(cnt_q) + CNT_ONE)
      else $error("normal count wrong");
   chk_ovf_wrap:   assert property ((tk_run && wm == WM_NORMAL && cnt_q == CNT_MAX)
                      |=> cnt_q == CNT_BOTTOM && flags_q[FL_OVF])
      else $error("wrap overflow missing");
   chk_ctc_clear:  assert property ((tk_run && wm == WM_CTC && cnt_q == cmp_a)
                      |=> cnt_q == CNT_BOTTOM)
      else $error("ctc clear missing");
   chk_block_hit:  assert property (cnt_wr |=> !hit_a && !hit_b)
      else $error("match after counter write");
   chk_flag_late:  assert property ((ce_i && hit_a) |=> flags_q[FL_MA])
      else $error("match flag not set");
   chk_flag_clear: assert property ((wr_i && ce_i && addr_i == ADR_FLAGS
                      && wdata_i[FL_MA] && !hit_a) |=> !flags_q[FL_MA])
      else $error("flag not cleared");
   chk_irq_and:    assert property (ce_i ##1 ce_i
                      |-> irq_o == ($past(flags_q) & $past(mask_q)))
      else $error("irq not flag and mask");
   chk_pin_ovr:    assert property ((ce_i && ctrl_a_q[CA_OMA +: 2] != OM_OFF)
                      |=> pin_o[0] == $past(oc_a))
      else $error("pin override wrong");
   cov_ctc:   cover property (tk_run && wm == WM_CTC && at_top);
   cov_fast:  cover property (tk_run && wrap);
   cov_force: cover property (wr_b && wdata_i[CB_FA] && !wm[0]);
endmodule
`default_nettype wire

// ### bench/tc8_cpu_model.sv
`default_nettype none
// ======================================================
// Processor side of the register port.
module tc8_cpu_model
   import tc8_pkg::*;
(
   // Clock.
   input  wire logic       clk_i,
   // Register port.
   output logic      [2:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i,
   // Interrupt service.
   input  wire logic       ack_en_i,
   input  wire logic [2:0] irq_i,
   output logic      [2:0] ack_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      addr_o  = ADR_CTRL_A;
      wdata_o = RST_BYTE;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      ack_o   = 3'h0;
   end

   // Acknowledges each pending request on alternate cycles while service is enabled.
   always @(posedge clk_i) begin
      ack_o <= ack_en_i ? (irq_i & ~ack_o) : 3'h0;
   end

   // One write, then the data lines no longer hold the written byte.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
      @(posedge clk_i);
   endtask

   // One read; the data are taken in the cycle after the strobe.
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      #1;
      d = rdata_i;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
`default_nettype none
`define CHK(nm, ex, got) begin \
   n_tests++; \
   if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %0h got %0h", nm, ex, got); \
   end \
end
// ======================================================
// Testbench top.
module tb
   import tc8_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic       core_clk;
   logic       rstn;
   logic       ce;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       presc_tick = 1'b0;
   logic       presc_on = 1'b0;
   logic       ext_clk;
   logic [2:0] irq_ack;
   logic [2:0] irq;
   logic [1:0] port_data;
   logic [1:0] port_dir;
   logic [1:0] pin;
   logic [1:0] pin_oe_n;
   logic       ack_en;
   int         error_cnt;
   int         n_tests;
   int         cyc;
   int         ptk;

   tc8_timer uut (
      .core_clk_i  (core_clk),
      .rstn_i      (rstn),
      .ce_i        (ce),
      .addr_i      (addr),
      .wdata_i     (wdata),
      .wr_i        (wr),
      .rd_i        (rd),
      .rdata_o     (rdata),
      .presc_tick_i(presc_tick),
      .ext_clk_i   (ext_clk),
      .irq_ack_i   (irq_ack),
      .irq_o       (irq),
      .port_data_i (port_data),
      .port_dir_i  (port_dir),
      .pin_o       (pin),
      .pin_oe_n_o  (pin_oe_n)
   );

   tc8_cpu_model cpu (
      .clk_i   (core_clk),
      .addr_o  (addr),
      .wdata_o (wdata),
      .wr_o    (wr),
      .rd_o    (rd),
      .rdata_i (rdata),
      .ack_en_i(ack_en),
      .irq_i   (irq),
      .ack_o   (irq_ack)
   );

   // ======================================================
   // Clock, side inputs and hang limit.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      presc_tick <= 1'($urandom());
      if (presc_on && presc_tick) begin
         ptk++;
      end
      if (wr && addr == ADR_CTRL_B) begin
         presc_on <= (wdata[CB_CS +: 3] == 3'h2);
      end
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   // ======================================================
   // Expectation helpers.
   function automatic logic [7:0] ctc_after(logic [7:0] c, logic [7:0] top, int n);
      for (int k = 0; k < n; k++) begin
         c = (c == top) ? CNT_BOTTOM : c + CNT_ONE;
      end
      return c;
   endfunction

   function automatic logic exp_oc(logic [1:0] om, logic prev);
      case (om)
         OM_SET:    return 1'b1;
         OM_CLEAR:  return 1'b0;
         OM_TOGGLE: return ~prev;
         default:   return prev;
      endcase
   endfunction

   // Runs the counter on the core clock for n ticks, n at least 2.
   task automatic run(int n);
      cpu.wr(ADR_CTRL_B, {5'h00, CS_CORE});
      repeat (n - 2) @(posedge core_clk);
      cpu.wr(ADR_CTRL_B, 8'h00);
   endtask

   task automatic final_report();
      $display("Checks %0d, errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ======================================================
   // Main sequence.
   initial begin
      logic [7:0] v;
      logic [7:0] r;
      logic       oc;
      logic [1:0] oms [4];
      logic [2:0] srcs [3];
      int         p0;
      rstn       = 1'b0;
      ce         = 1'b1;
      ext_clk    = 1'b0;
      port_data  = 2'h0;
      port_dir   = 2'h0;
      ack_en     = 1'b0;
      oc         = 1'b0;
      oms        = '{OM_CLEAR, OM_TOGGLE, OM_CLEAR, OM_SET};
      srcs       = '{3'h2, CS_EXT_F, CS_EXT_R};
      r = 8'($urandom(32'hFE4665D7));
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         cpu.rd(3'(i), r);
         `CHK("reset value", RST_BYTE, r)
      end
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? CNT_MAX : 8'($urandom());
         cpu.wr(ADR_COUNT, v);
         repeat (3) @(posedge core_clk);
         cpu.rd(ADR_COUNT, r);
         `CHK("stopped count", v, r)
      end
      cpu.wr(ADR_COUNT, CNT_MAX);
      run(2);
      cpu.rd(ADR_COUNT, r);
      `CHK("wrap count", ctc_after(CNT_MAX, CNT_MAX, 2), r)
      cpu.rd(ADR_FLAGS, r);
      `CHK("overflow flag", 1'b1, r[FL_OVF])
      cpu.wr(ADR_FLAGS, 8'h00);
      cpu.rd(ADR_FLAGS, r);
      `CHK("flag kept", 1'b1, r[FL_OVF])
      cpu.wr(ADR_FLAGS, 8'h01 << FL_OVF);
      cpu.rd(ADR_FLAGS, r);
      `CHK("flag cleared", 1'b0, r[FL_OVF])
      cpu.wr(ADR_CMP_A, 8'h10);
      cpu.wr(ADR_COUNT, 8'h10);
      cpu.wr(ADR_FLAGS, 8'h07);
      run(2);
      cpu.rd(ADR_FLAGS, r);
      `CHK("blocked match", 1'b0, r[FL_MA])
      cpu.wr(ADR_COUNT, 8'h0F);
      run(3);
      cpu.rd(ADR_COUNT, r);
      `CHK("count up", ctc_after(8'h0F, CNT_MAX, 3), r)
      cpu.rd(ADR_FLAGS, r);
      `CHK("match flag", 1'b1, r[FL_MA])
      cpu.wr(ADR_CTRL_B, {5'h00, CS_CORE});
      cpu.wr(ADR_COUNT, 8'h40);
      cpu.wr(ADR_CTRL_B, 8'h00);
      cpu.rd(ADR_COUNT, r);
      `CHK("write wins", 8'h42, r)
      cpu.wr(ADR_CTRL_A, {6'h00, WM_CTC[1:0]});
      cpu.wr(ADR_CMP_A, 8'h03);
      cpu.wr(ADR_COUNT, 8'h00);
      cpu.wr(ADR_FLAGS, 8'h07);
      run(5);
      cpu.rd(ADR_COUNT, r);
      `CHK("ctc count", ctc_after(8'h00, 8'h03, 5), r)
      cpu.wr(ADR_MASK, 8'h01 << FL_MA);
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("irq request", 3'b010, irq)
      ack_en <= 1'b1;
      repeat (4) @(posedge core_clk);
      ack_en <= 1'b0;
      cpu.rd(ADR_FLAGS, r);
      `CHK("serviced flag", 1'b0, r[FL_MA])
      for (int m = 0; m < 2; m++) begin
         cpu.wr(ADR_CTRL_A, 8'h00);
         cpu.wr(ADR_CMP_B, 8'h20);
         cpu.wr(ADR_CTRL_A, (m == 0) ? {6'h00, WM_FST_MAX[1:0]} : 8'h00);
         cpu.wr(ADR_CMP_B, 8'h05);
         cpu.wr(ADR_COUNT, 8'h03);
         cpu.wr(ADR_FLAGS, 8'h07);
         run(4);
         cpu.rd(ADR_FLAGS, r);
         `CHK("buffered compare", (m == 1), r[FL_MB])
         cpu.rd(ADR_CMP_B, r);
         `CHK("compare read", 8'h05, r)
      end
      cpu.wr(ADR_CTRL_A, 8'h00);
      cpu.wr(ADR_FLAGS, 8'h07);
      port_dir  <= 2'($urandom());
      port_data <= {1'($urandom()), 1'b0};
      for (int i = 0; i < 4; i++) begin
         cpu.wr(ADR_CTRL_A, 8'({oms[i], 6'h00}));
         cpu.wr(ADR_CTRL_B, 8'h01 << CB_FA);
         #1;
         oc = exp_oc(oms[i], oc);
         `CHK("forced output", oc, pin[0])
      end
      cpu.rd(ADR_FLAGS, r);
      `CHK("force no flag", 1'b0, r[FL_MA])
      cpu.wr(ADR_CTRL_A, 8'({OM_TOGGLE, 4'h0, WM_CTC[1:0]}));
      #1;
      `CHK("kept output", oc, pin[0])
      cpu.wr(ADR_CTRL_A, 8'h00);
      #1;
      `CHK("port data", port_data, pin)
      `CHK("pin enable", ~port_dir, pin_oe_n)
      cpu.wr(ADR_CTRL_A, {6'h00, WM_PC_MAX[1:0]});
      cpu.wr(ADR_COUNT, 8'hFD);
      run(5);
      cpu.rd(ADR_COUNT, r);
      `CHK("dual slope", 8'hFC, r)
      cpu.wr(ADR_CTRL_A, 8'h00);
      for (int s = 0; s < 3; s++) begin
         cpu.wr(ADR_COUNT, CNT_BOTTOM);
         p0 = ptk;
         cpu.wr(ADR_CTRL_B, {5'h00, srcs[s]});
         for (int k = 0; k < 10; k++) begin
            repeat (4) @(posedge core_clk);
            ext_clk <= ~ext_clk;
         end
         repeat (6) @(posedge core_clk);
         cpu.wr(ADR_CTRL_B, 8'h00);
         cpu.rd(ADR_COUNT, r);
         `CHK("tick source", (s == 0) ? 8'(ptk - p0) : 8'h05, r)
      end
      cpu.wr(ADR_COUNT, 8'h80);
      cpu.wr(ADR_CTRL_B, {5'h00, CS_CORE});
      ce <= 1'b0;
      repeat (6) @(posedge core_clk);
      ce <= 1'b1;
      cpu.wr(ADR_CTRL_B, 8'h00);
      cpu.rd(ADR_COUNT, r);
      `CHK("frozen count", 8'h82, r)
      final_report();
   end
endmodule
`default_nettype wire
